// file: logic/sio_pkg.sv
// package for the subsystem pin i/o control port
// assumes a 16-bit cpu data path and a byte-offset address space
package sio_pkg;

  localparam logic [15:0] SIO_CTRL_OFFSET   = 16'h003c;
  localparam int          SIO_TSEL_BIT      = 15;
  localparam int          SIO_RSV_HI        = 14;
  localparam int          SIO_RSV_LO        = 12;
  localparam int          SIO_DIR_LO        = 8;
  localparam int          SIO_ROM_BIT       = 7;
  localparam int          SIO_SEL_BIT       = 6;
  localparam int          SIO_GRANT_BIT     = 5;
  localparam int          SIO_REQ_BIT       = 4;
  localparam int          SIO_VAL_LO        = 0;
  localparam logic [3:0]  SIO_DIR_RESET     = 4'h0;
  localparam logic [3:0]  SIO_VAL_RESET     = 4'h0;
  localparam logic        SIO_TSEL_RESET    = 1'h0;
  localparam logic        SIO_REQ_RESET     = 1'h0;
  localparam logic        SIO_ROM_RESET     = 1'h0;
  localparam logic [1:0]  SIO_INIT_CYCLES   = 2'h3;

  typedef enum logic [1:0] {
    SIO_ARB_IDLE = 2'b00,
    SIO_ARB_OWN  = 2'b01,
    SIO_ARB_PEER = 2'b10
  } sio_arb_t;

endpackage

// file: logic/sio_ctrl.sv
// subsystem pin i/o control port: one 16-bit control register, four
// two-way pins, timer on pin 3 when the strap is low, rom map enable, external bus arbitration
// assumes cpu strobes and timer pulse on REF_CLK_IN; pins, strap and
// peer arbitration signals are asynchronous and are synchronised here
`timescale 1ns/100ps
module sio_ctrl
  import sio_pkg::*;
#(
  parameter int         ADDR_W    = 16,
  parameter logic       SUBSYS_ID = 1'h0
)(
  input  wire logic              REF_CLK_IN,       // 40 mhz clock
  input  wire logic              RESET_IN,         // core reset, high
  input  wire logic [ADDR_W-1:0] REG_ADDR_IN,      // cpu data address
  input  wire logic              REG_WR_IN,        // write strobe
  input  wire logic              REG_RD_IN,        // read strobe
  input  wire logic [15:0]       REG_WDATA_IN,     // write data
  output logic      [15:0]       REG_RDATA_OUT,    // read data
  input  wire logic [3:0]        PIN_IN,           // pin levels
  output logic      [3:0]        PIN_OUT,          // pin drive value
  output logic      [3:0]        PIN_OE_OUT,       // pin drive enable
  input  wire logic              TIMER_PULSE_IN,   // timer output
  input  wire logic              STRAP_IN,         // shared-bus strap
  output logic                   ROM_MAP_OUT,      // rom mapped in
  output logic                   BRANCH_COND_OUT,  // cpu branch condition
  output logic                   EXT_BUS_REQ_OUT,  // own bus request
  input  wire logic              PEER_REQ_IN,      // peer request (a only)
  output logic                   PEER_GRANT_OUT,   // peer grant (a only)
  input  wire logic              ARB_GRANT_IN      // grant from a (b only)
);

  logic [6:0]  in_meta;
  logic [6:0]  in_s;
  logic [3:0]  pin_s;
  logic        strap_s;
  logic        peer_req_s;
  logic        arb_grant_s;
  logic        timer_pin_select;
  logic [3:0]  pin_direction;
  logic [3:0]  pin_value;
  logic        rom_map_enable;
  logic        ext_bus_request;
  logic        ext_bus_grant;
  logic [1:0]  init_cnt;
  sio_arb_t    arb_state;
  sio_arb_t    next_arb_state;

  wire         reg_hit     = (REG_ADDR_IN == ADDR_W'(SIO_CTRL_OFFSET));
  wire         reg_wr      = REG_WR_IN && reg_hit;
  wire         reg_rd      = REG_RD_IN && reg_hit;
  wire         init_load   = (init_cnt == SIO_INIT_CYCLES - 2'h1);
  wire         timer_on    = timer_pin_select && !strap_s;
  wire [3:0]   drive_en    = {pin_direction[3] | timer_on,
                              pin_direction[2:0]};
  wire [3:0]   drive_val   = {timer_on ? TIMER_PULSE_IN : pin_value[3],
                              pin_value[2:0]};
  wire [3:0]   read_val;
  wire [15:0]  ctrl_word;

  // per-pin readback: driven pins echo their data, inputs the pin level
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_rd
      assign read_val[g] = pin_direction[g] ? pin_value[g] : pin_s[g];
    end
  endgenerate
  assign read_val[3] = timer_on ? TIMER_PULSE_IN :
                       (pin_direction[3] ? pin_value[3] : pin_s[3]);

  assign ctrl_word = {timer_pin_select,
                      3'h0,
                      pin_direction,
                      rom_map_enable,
                      SUBSYS_ID,
                      ext_bus_grant,
                      ext_bus_request,
                      read_val};

  assign pin_s       = in_s[3:0];
  assign strap_s     = in_s[4];
  assign peer_req_s  = in_s[5];
  assign arb_grant_s = in_s[6];

  // two-stage synchroniser for every asynchronous input
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      in_meta <= 7'h00;
      in_s    <= 7'h00;
    end
    else
    begin
      in_meta <= {ARB_GRANT_IN, PEER_REQ_IN, STRAP_IN, PIN_IN};
      in_s    <= in_meta;
    end
  end

  // control bits; the strap-derived rom enable loads once the strap
  // and pin 0 have crossed the synchroniser after reset release
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      timer_pin_select <= SIO_TSEL_RESET;
      pin_direction    <= SIO_DIR_RESET;
      pin_value        <= SIO_VAL_RESET;
      rom_map_enable   <= SIO_ROM_RESET;
      ext_bus_request  <= SIO_REQ_RESET;
      init_cnt         <= 2'h0;
    end
    else
    begin
      if (init_cnt != SIO_INIT_CYCLES)
        init_cnt <= init_cnt + 2'h1;
      if (init_load)
        rom_map_enable <= strap_s & pin_s[0];
      else if (reg_wr)
        rom_map_enable <= REG_WDATA_IN[SIO_ROM_BIT];
      if (reg_wr)
      begin
        timer_pin_select <= REG_WDATA_IN[SIO_TSEL_BIT];
        pin_direction    <= REG_WDATA_IN[SIO_DIR_LO +: 4];
        pin_value        <= REG_WDATA_IN[SIO_VAL_LO +: 4];
        ext_bus_request  <= REG_WDATA_IN[SIO_REQ_BIT];
      end
    end
  end

  // arbitration: subsystem a owns the arbiter, b takes a's grant
  always_comb
  begin
    next_arb_state = arb_state;
    case (arb_state)
      SIO_ARB_IDLE:
        if (ext_bus_request)
          next_arb_state = SIO_ARB_OWN;
        else if (peer_req_s)
          next_arb_state = SIO_ARB_PEER;
      SIO_ARB_OWN:
        if (!ext_bus_request)
          next_arb_state = SIO_ARB_IDLE;
      SIO_ARB_PEER:
        if (!peer_req_s)
          next_arb_state = SIO_ARB_IDLE;
      default:
        next_arb_state = SIO_ARB_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
      arb_state <= SIO_ARB_IDLE;
    else if (SUBSYS_ID == 1'h0)
      arb_state <= next_arb_state;
  end

  assign ext_bus_grant = (SUBSYS_ID == 1'h0) ?
                         (arb_state == SIO_ARB_OWN) : arb_grant_s;

  // registered outputs
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      REG_RDATA_OUT   <= 16'h0000;
      PIN_OUT         <= 4'h0;
      PIN_OE_OUT      <= 4'h0;
      ROM_MAP_OUT     <= 1'h0;
      BRANCH_COND_OUT <= 1'h1;
      EXT_BUS_REQ_OUT <= 1'h0;
      PEER_GRANT_OUT  <= 1'h0;
    end
    else
    begin
      REG_RDATA_OUT   <= reg_rd ? ctrl_word : 16'h0000;
      PIN_OUT         <= drive_val;
      PIN_OE_OUT      <= drive_en;
      ROM_MAP_OUT     <= rom_map_enable;
      BRANCH_COND_OUT <= pin_direction[2] ? 1'h1 : pin_s[2];
      EXT_BUS_REQ_OUT <= ext_bus_request;
      PEER_GRANT_OUT  <= (SUBSYS_ID == 1'h0) &&
                         (arb_state == SIO_ARB_PEER);
    end
  end

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);

  dir_follows_a: assert property (
    reg_wr |=> ##1 PIN_OE_OUT[2:0] == $past(REG_WDATA_IN[10:8], 2) &&
                   ($past(timer_on) ||
                    PIN_OE_OUT[3] == $past(REG_WDATA_IN[11], 2)))
    else $error("pin enable does not follow direction write");
  reset_inputs_a: assert property (
    $fell(RESET_IN) |-> PIN_OE_OUT == 4'h0 && pin_direction == 4'h0)
    else $error("pins not inputs after reset");
  addr_decode_a: assert property (
    REG_RD_IN && !reg_hit |=> REG_RDATA_OUT == 16'h0000)
    else $error("unmapped read returned data");
  timer_drive_a: assert property (
    timer_on |=> PIN_OE_OUT[3] && PIN_OUT[3] == $past(TIMER_PULSE_IN))
    else $error("timer not on pin 3");
  reserved_zero_a: assert property (
    reg_rd |=> REG_RDATA_OUT[14:12] == 3'h0)
    else $error("reserved bits read nonzero");
  input_readback_a: assert property (
    reg_rd && !pin_direction[0] |=> REG_RDATA_OUT[0] == $past(pin_s[0]))
    else $error("input pin 0 readback wrong");
  rom_strap_a: assert property (
    init_load |=> rom_map_enable == $past(strap_s & pin_s[0]))
    else $error("rom enable not taken from strap");
  core_sel_a: assert property (
    reg_rd |=> REG_RDATA_OUT[6] == SUBSYS_ID)
    else $error("subsystem select wrong");
  branch_cond_a: assert property (
    !pin_direction[2] ##1 !$past(reg_wr)
      |-> BRANCH_COND_OUT == $past(pin_s[2]))
    else $error("branch condition not pin 2");
  strap_block_a: assert property (
    strap_s && !pin_direction[3] |=> !PIN_OE_OUT[3])
    else $error("timer on pin 3 in shared-bus mode");
  one_grant_a: assert property (
    !(ext_bus_grant && PEER_GRANT_OUT && SUBSYS_ID == 1'h0))
    else $error("both subsystems granted");
  grant_hold_a: assert property (
    arb_state == SIO_ARB_OWN && ext_bus_request
      |=> arb_state == SIO_ARB_OWN)
    else $error("grant dropped while requested");

  cov_timer: cover property (timer_on ##1 PIN_OE_OUT[3]);
  cov_handover: cover property (
    arb_state == SIO_ARB_OWN ##1 arb_state == SIO_ARB_IDLE
      ##1 arb_state == SIO_ARB_PEER);
  cov_rom_in: cover property (init_load && strap_s && pin_s[0]);
  cov_output: cover property (reg_wr ##1 PIN_OE_OUT == 4'hf);

endmodule

// file: verif/sio_far_model.sv
// far side of the pin i/o port: the board on the four pins and the peer
// subsystem's bus request; assumes the dut wins when both drive a pin
`timescale 1ns/100ps
module sio_far_model
  import sio_pkg::*;
(
  input  wire logic       clk_in,        // subsystem clock
  input  wire logic [3:0] pin_drv_in,    // dut drive value
  input  wire logic [3:0] pin_oe_in,     // dut drive enable
  input  wire logic [3:0] ext_val_in,    // board drive value
  input  wire logic [3:0] ext_oe_in,     // board drive enable
  input  wire logic       peer_want_in,  // peer software wants the bus
  output logic      [3:0] pin_level_out, // resolved pin levels
  output logic            peer_req_out   // peer request line
);
  logic flip;
  initial flip = 1'h0;
  initial peer_req_out = 1'h0;
  // an undriven pin wanders so a stale level is never read as valid
  always @(posedge clk_in) flip <= ~flip;
  // peer raises and drops its request only after a clock edge
  always @(posedge clk_in) peer_req_out <= peer_want_in;
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      pin_level_out[i] = pin_oe_in[i] ? pin_drv_in[i] :
                         ext_oe_in[i] ? ext_val_in[i] : flip;
    end
  end
endmodule

// file: verif/sio_ctrl_test.sv
// self-checking bench for the pin i/o control port, subsystem a
// assumes the far model on the pins and the peer request line
`timescale 1ns/100ps
module sio_ctrl_test
  import sio_pkg::*;
;
  logic        clk, rst, wr, rd, tmr, strap, peer_want;
  logic [15:0] addr, wdata, rdata, rdata_b;
  logic [3:0]  pin_in, pin_out, pin_oe, ext_val, ext_oe;
  logic        rom, brc, own_req, peer_req, peer_gnt;
  int          n_mismatch, checks;
  sio_ctrl #(.ADDR_W(16), .SUBSYS_ID(1'h0)) dut (
    .REF_CLK_IN(clk), .RESET_IN(rst), .REG_ADDR_IN(addr),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_WDATA_IN(wdata),
    .REG_RDATA_OUT(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE_OUT(pin_oe), .TIMER_PULSE_IN(tmr), .STRAP_IN(strap),
    .ROM_MAP_OUT(rom), .BRANCH_COND_OUT(brc), .EXT_BUS_REQ_OUT(own_req),
    .PEER_REQ_IN(peer_req), .PEER_GRANT_OUT(peer_gnt),
    .ARB_GRANT_IN(1'h0));
  // subsystem b shares the bus; a's grant to its peer is b's grant
  sio_ctrl #(.ADDR_W(16), .SUBSYS_ID(1'h1)) dut_b (
    .REF_CLK_IN(clk), .RESET_IN(rst), .REG_ADDR_IN(addr),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_WDATA_IN(wdata),
    .REG_RDATA_OUT(rdata_b), .PIN_IN(pin_in), .PIN_OUT(),
    .PIN_OE_OUT(), .TIMER_PULSE_IN(tmr), .STRAP_IN(strap),
    .ROM_MAP_OUT(), .BRANCH_COND_OUT(), .EXT_BUS_REQ_OUT(),
    .PEER_REQ_IN(1'h0), .PEER_GRANT_OUT(),
    .ARB_GRANT_IN(peer_gnt));
  sio_far_model far (
    .clk_in(clk), .pin_drv_in(pin_out), .pin_oe_in(pin_oe),
    .ext_val_in(ext_val), .ext_oe_in(ext_oe), .peer_want_in(peer_want),
    .pin_level_out(pin_in), .peer_req_out(peer_req));
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    @(negedge clk);
    chk("register word", exp, rdata);
  endtask
  task automatic pins(input logic [3:0] oe, input logic [3:0] val);
    // called off the clock edge, right after a read
    chk("pin enables", {12'h0, oe}, {12'h0, pin_oe});
    chk("pin values", {12'h0, val}, {12'h0, pin_out & pin_oe});
  endtask
  task automatic wait_peer(input logic lvl);
    int i;
    i = 0;
    while (peer_gnt !== lvl && i < 40)
    begin
      @(negedge clk);
      i++;
    end
    chk("peer grant", {15'h0, lvl}, {15'h0, peer_gnt});
    if (peer_gnt !== lvl)
      results();
  endtask
  task automatic do_reset();
    rst <= 1'h1;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    repeat (6) @(posedge clk);
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    $display("ERROR run length expected 5000 seen more");
    results();
  end
  initial
  begin
    {rst, wr, rd, tmr, strap, peer_want} = 6'h20;
    {addr, wdata} = 32'h0;
    ext_val = 4'ha;
    ext_oe = 4'hf;
    n_mismatch = 0;
    checks = 0;
    do_reset();
    rd_reg(SIO_CTRL_OFFSET, 16'h000a);
    chk("subsys b word", 16'h004a, rdata_b);
    pins(4'h0, 4'h0);
    chk("rom map", 16'h0, {15'h0, rom});
    chk("branch cond", 16'h0, {15'h0, brc});
    @(posedge clk);
    tmr <= 1'h1;
    wr_reg(SIO_CTRL_OFFSET, 16'hffff);
    repeat (3) @(posedge clk);
    rd_reg(SIO_CTRL_OFFSET, 16'h8fbf);
    pins(4'hf, 4'hf);
    chk("branch cond", 16'h1, {15'h0, brc});
    @(posedge clk);
    tmr <= 1'h0;
    repeat (3) @(posedge clk);
    rd_reg(SIO_CTRL_OFFSET, 16'h8fb7);
    pins(4'hf, 4'h7);
    rd_reg(16'h003e, 16'h0000);
    wr_reg(16'h003e, 16'h0000);
    rd_reg(SIO_CTRL_OFFSET, 16'h8fb7);
    @(posedge clk);
    peer_want <= 1'h1;
    repeat (10) @(negedge clk);
    chk("peer grant", 16'h0, {15'h0, peer_gnt});
    wr_reg(SIO_CTRL_OFFSET, 16'h0f05);
    wait_peer(1'h1);
    wr_reg(SIO_CTRL_OFFSET, 16'h0f15);
    repeat (4) @(posedge clk);
    rd_reg(SIO_CTRL_OFFSET, 16'h0f15);
    chk("subsys b word", 16'h0f75, rdata_b);
    chk("bus request", 16'h1, {15'h0, own_req});
    pins(4'hf, 4'h5);
    @(posedge clk);
    peer_want <= 1'h0;
    wait_peer(1'h0);
    repeat (3) @(posedge clk);
    rd_reg(SIO_CTRL_OFFSET, 16'h0f35);
    wr_reg(SIO_CTRL_OFFSET, 16'h0000);
    ext_val <= 4'h4;
    repeat (5) @(posedge clk);
    rd_reg(SIO_CTRL_OFFSET, 16'h0004);
    chk("branch cond", 16'h1, {15'h0, brc});
    chk("bus request", 16'h0, {15'h0, own_req});
    @(posedge clk);
    strap <= 1'h1;
    ext_val <= 4'h1;
    tmr <= 1'h1;
    do_reset();
    rd_reg(SIO_CTRL_OFFSET, 16'h0081);
    chk("rom map", 16'h1, {15'h0, rom});
    wr_reg(SIO_CTRL_OFFSET, 16'h8800);
    repeat (3) @(posedge clk);
    rd_reg(SIO_CTRL_OFFSET, 16'h8801);
    pins(4'h8, 4'h0);
    chk("rom map", 16'h0, {15'h0, rom});
    results();
  end
endmodule
